// File: src/urx_top.sv
// Operation
// RULE_01: Each FIFO entry keeps its framing error.
// RULE_02: Missing stop bit flags framing error.
// RULE_03: Framing flag read-only, oldest character only.
// RULE_04: Data read pops; flags follow next.
// RULE_05: Framing error never stops reception.
// RULE_06: Port off resets unit, clears framing.
// RULE_07: Receive-enable off keeps framing flag.
// RULE_08: Framing error alone raises no interrupt.
// RULE_09: Software reads framing flag before data.
// RULE_10: FIFO holds exactly two characters.
// RULE_11: Third character into full FIFO overruns.
// RULE_12: Overrun keeps data, blocks new characters.
// RULE_13: Receive-enable or port off clears overrun.
// RULE_14: Nine-bit mode shifts nine data bits.
// RULE_15: Ninth bit shows oldest character's bit.
// RULE_16: Software reads ninth bit before data.
// RULE_17: Data read returns low byte; empty harmless.
// RULE_18: Data-available while FIFO not empty.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module urx_top (
  input wire logic sys_clk_i, // 125 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic rx_pin_i, // Serial line input
  input wire logic [3:0] addr_i, // Register address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [15:0] rdata_o, // Read data, one cycle later
  output logic rx_avail_o, // Receive data available
  output logic irq_o // Level interrupt
);
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic serial_port_on_ff;
  logic nine_bit_rx_select_ff;
  logic continuous_rx_on_ff;
  logic overrun_err_flag_ff;
  logic [15:0] baud_div_ff;
  logic [urx_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [urx_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [urx_pkg::CHAR_W-1:0] fifo_data_ff [urx_pkg::FIFO_DEPTH];
  logic [urx_pkg::FIFO_DEPTH-1:0] fifo_framing_err_flag_ff;
  logic rd_ptr_ff;
  logic wr_ptr_ff;
  logic [1:0] count_ff;
  logic unit_rst;
  logic tick;
  logic done;
  logic [8:0] rx_char;
  logic rx_framing_err_flag;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic overrun_evt;
  logic framing_err_flag;
  logic rx_ninth_bit;
  logic [15:0] status_word;
  logic [15:0] nxt_rdata;

  // ---------------------------------------------------------------------------
  // Line synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end
    else
    begin
      rx_meta_ff <= rx_pin_i;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // Port off holds the serial unit in reset except the control and interrupt registers [RULE_06]
  assign unit_rst = rst_i || !serial_port_on_ff;

  urx_tick_gen u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(unit_rst),
    .div_i(baud_div_ff),
    .tick_o(tick)
  );

  urx_frame_rx u_frame (
    .sys_clk_i(sys_clk_i),
    .rst_i(unit_rst || !continuous_rx_on_ff),
    .tick_i(tick),
    .rx_i(rx_sync_ff),
    .nine_bit_i(nine_bit_rx_select_ff),
    .done_o(done),
    .char_o(rx_char),
    .framing_err_flag_o(rx_framing_err_flag)
  );

  // ---------------------------------------------------------------------------
  // Two-entry receive FIFO
  // ---------------------------------------------------------------------------
  assign fifo_full = (count_ff == 2'(urx_pkg::FIFO_DEPTH)); // [RULE_10]
  assign fifo_empty = (count_ff == 2'h0);
  assign pop = rd_i && (addr_i == urx_pkg::ADDR_RX_DATA) && !fifo_empty; // [RULE_04] [RULE_17]
  // Framing errors do not gate storage; overrun does [RULE_05] [RULE_12]
  assign push = done && !overrun_err_flag_ff && (!fifo_full || pop);
  assign overrun_evt = done && !overrun_err_flag_ff && fifo_full && !pop; // [RULE_11]

  // Only reset or port off empties the FIFO; receive-enable off keeps entries and their framing flags [RULE_07]

  always_ff @(posedge sys_clk_i)
  begin
    if (unit_rst)
    begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      fifo_framing_err_flag_ff <= '0;
      for (int i = 0; i < urx_pkg::FIFO_DEPTH; i++)
      begin
        fifo_data_ff[i] <= 9'h000;
      end
    end
    else
    begin
      if (push)
      begin
        fifo_data_ff[wr_ptr_ff] <= rx_char;
        fifo_framing_err_flag_ff[wr_ptr_ff] <= rx_framing_err_flag; // [RULE_01]
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
      begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + 2'(push) - 2'(pop);
    end
  end

  // Oldest entry drives the visible flags [RULE_03] [RULE_15]
  assign framing_err_flag = !fifo_empty && fifo_framing_err_flag_ff[rd_ptr_ff];
  assign rx_ninth_bit = !fifo_empty && fifo_data_ff[rd_ptr_ff][urx_pkg::CHAR_W-1];
  assign rx_avail_o = !fifo_empty; // [RULE_18]

  // ---------------------------------------------------------------------------
  // Overrun flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (unit_rst || !continuous_rx_on_ff)
    begin
      overrun_err_flag_ff <= 1'b0; // [RULE_13]
    end
    else if (overrun_evt)
    begin
      overrun_err_flag_ff <= 1'b1; // [RULE_11]
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      serial_port_on_ff <= 1'b0;
      nine_bit_rx_select_ff <= 1'b0;
      continuous_rx_on_ff <= 1'b0;
      baud_div_ff <= urx_pkg::BAUD_DIV_RST;
      irq_mask_ff <= '0;
    end
    else if (wr_i)
    begin
      // Framing and ninth-bit fields are read-only [RULE_03]
      if (addr_i == urx_pkg::ADDR_RX_STATUS_CTRL)
      begin
        serial_port_on_ff <= wdata_i[urx_pkg::BIT_SERIAL_PORT_ON];
        nine_bit_rx_select_ff <= wdata_i[urx_pkg::BIT_NINE_BIT_SEL];
        continuous_rx_on_ff <= wdata_i[urx_pkg::BIT_CONT_RX_ON];
      end
      if (addr_i == urx_pkg::ADDR_IRQ_MASK)
      begin
        irq_mask_ff <= wdata_i[urx_pkg::IRQ_W-1:0];
      end
      if (addr_i == urx_pkg::ADDR_BAUD_DIV)
      begin
        baud_div_ff <= wdata_i;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_ff <= '0;
    end
    else
    begin
      // No framing-error source here [RULE_08]
      irq_stat_ff <= (irq_stat_ff & ~((wr_i && addr_i == urx_pkg::ADDR_IRQ_STATUS) ?
                      wdata_i[urx_pkg::IRQ_W-1:0] : '0)) | {overrun_evt, push};
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  always_comb
  begin
    status_word = 16'h0000;
    status_word[urx_pkg::BIT_SERIAL_PORT_ON] = serial_port_on_ff;
    status_word[urx_pkg::BIT_NINE_BIT_SEL] = nine_bit_rx_select_ff;
    status_word[urx_pkg::BIT_CONT_RX_ON] = continuous_rx_on_ff;
    status_word[urx_pkg::BIT_FRAMING_ERR] = framing_err_flag;
    status_word[urx_pkg::BIT_OVERRUN_ERR] = overrun_err_flag_ff;
    status_word[urx_pkg::BIT_NINTH_BIT] = rx_ninth_bit;
    nxt_rdata = 16'h0000;
    unique case (addr_i)
      urx_pkg::ADDR_RX_DATA: nxt_rdata = fifo_empty ? 16'h0000 :
                                         {8'h00, fifo_data_ff[rd_ptr_ff][urx_pkg::DATA_W-1:0]};
      urx_pkg::ADDR_RX_STATUS_CTRL: nxt_rdata = status_word;
      urx_pkg::ADDR_IRQ_STATUS: nxt_rdata = {14'h0000, irq_stat_ff};
      urx_pkg::ADDR_IRQ_MASK: nxt_rdata = {14'h0000, irq_mask_ff};
      urx_pkg::ADDR_BAUD_DIV: nxt_rdata = baud_div_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= rd_i ? nxt_rdata : 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_framing_err_flag_stored;
    @(posedge sys_clk_i) disable iff (rst_i)
    (push && fifo_empty && !pop) |=> (framing_err_flag == $past(rx_framing_err_flag));
  endproperty
  a_framing_err_flag_stored: assert property (p_framing_err_flag_stored) else $error("stored framing error lost"); // [RULE_01]

  property p_port_off_clears;
    @(posedge sys_clk_i) disable iff (rst_i)
    !serial_port_on_ff |=> !framing_err_flag && !overrun_err_flag_ff && !rx_avail_o;
  endproperty
  a_port_off_clears: assert property (p_port_off_clears) else $error("port off did not clear"); // [RULE_06]

  property p_continuous_rx_on_keeps_framing_err_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    ($fell(continuous_rx_on_ff) && serial_port_on_ff && !$past(pop) && !$past(push)) |-> $stable(framing_err_flag);
  endproperty
  a_continuous_rx_on_keeps_framing_err_flag: assert property (p_continuous_rx_on_keeps_framing_err_flag) else $error("framing flag moved"); // [RULE_07]

  property p_depth;
    @(posedge sys_clk_i) disable iff (rst_i)
    count_ff <= 2'(urx_pkg::FIFO_DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo over depth"); // [RULE_10]

  property p_overrun_set;
    @(posedge sys_clk_i) disable iff (unit_rst)
    (done && fifo_full && !pop && continuous_rx_on_ff) |=> overrun_err_flag_ff || !continuous_rx_on_ff;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged"); // [RULE_11]

  property p_overrun_blocks;
    @(posedge sys_clk_i) disable iff (rst_i)
    overrun_err_flag_ff |=> (count_ff <= $past(count_ff));
  endproperty
  a_overrun_blocks: assert property (p_overrun_blocks) else $error("push during overrun"); // [RULE_12]

  property p_overrun_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    !continuous_rx_on_ff |=> !overrun_err_flag_ff;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared"); // [RULE_13]

  property p_pop_advances;
    @(posedge sys_clk_i) disable iff (unit_rst)
    (pop && !push) |=> count_ff == $past(count_ff) - 2'h1;
  endproperty
  a_pop_advances: assert property (p_pop_advances) else $error("read did not pop"); // [RULE_04]

  property p_avail;
    @(posedge sys_clk_i) disable iff (rst_i)
    push |=> rx_avail_o;
  endproperty
  a_avail: assert property (p_avail) else $error("avail not raised"); // [RULE_18]

  property p_avail_drop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (pop && !push && count_ff == 2'h1) |=> !rx_avail_o;
  endproperty
  a_avail_drop: assert property (p_avail_drop) else $error("avail not dropped"); // [RULE_18]

  c_overrun: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(overrun_err_flag_ff));
  c_framing_err_flag: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(framing_err_flag));
  c_full: cover property (@(posedge sys_clk_i) disable iff (rst_i) fifo_full ##1 pop);
  c_ninth: cover property (@(posedge sys_clk_i) disable iff (rst_i) rx_ninth_bit && nine_bit_rx_select_ff);
endmodule // urx_top

// File: src/urx_pkg.sv
package urx_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_RX_DATA = 4'h0;
  localparam logic [3:0] ADDR_RX_STATUS_CTRL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_BAUD_DIV = 4'h4;

  // ---------------------------------------------------------------------------
  // Status/control bit positions
  // ---------------------------------------------------------------------------
  localparam int BIT_SERIAL_PORT_ON = 7;
  localparam int BIT_NINE_BIT_SEL = 6;
  localparam int BIT_CONT_RX_ON = 4;
  localparam int BIT_FRAMING_ERR = 2;
  localparam int BIT_OVERRUN_ERR = 1;
  localparam int BIT_NINTH_BIT = 0;

  // Interrupt status bits
  localparam int IRQ_RX_AVAIL = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_W = 2;

  // ---------------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------------
  localparam int FIFO_DEPTH = 2;
  localparam int CHAR_W = 9;
  localparam int DATA_W = 8;
  localparam int OVERSAMPLE = 16;
  localparam int MID_SAMPLE = 8;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0043;

  typedef enum logic [1:0] {
    URX_IDLE = 2'b00,
    URX_START = 2'b01,
    URX_DATA = 2'b11,
    URX_STOP = 2'b10
  } urx_state_t;

endpackage

// File: src/urx_tick_gen.sv
`timescale 1ns/1ps
module urx_tick_gen (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [15:0] div_i, // Divider reload value
  output logic tick_o // One-cycle oversample enable
);
  logic [15:0] cnt_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || cnt_ff == 16'h0000)
    begin
      cnt_ff <= div_i;
    end
    else
    begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_ff == 16'h0000);
    end
  end
endmodule // urx_tick_gen

// File: src/urx_frame_rx.sv
`timescale 1ns/1ps
module urx_frame_rx (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic tick_i, // Oversample enable
  input wire logic rx_i, // Synchronised serial input
  input wire logic nine_bit_i, // Nine data bits per character
  output logic done_o, // Character complete pulse
  output logic [8:0] char_o, // Received character
  output logic framing_err_flag_o // Stop bit missing
);
  urx_pkg::urx_state_t state_ff;
  logic [3:0] os_ff;
  logic [3:0] bit_ff;
  logic [8:0] rx_shift_reg_ff;

  // ---------------------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= urx_pkg::URX_IDLE;
      os_ff <= 4'h0;
      bit_ff <= 4'h0;
      rx_shift_reg_ff <= 9'h000;
      done_o <= 1'b0;
      char_o <= 9'h000;
      framing_err_flag_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (tick_i)
      begin
        os_ff <= os_ff + 4'h1;
        unique case (state_ff)
          urx_pkg::URX_IDLE:
          begin
            os_ff <= 4'h0;
            if (!rx_i)
            begin
              state_ff <= urx_pkg::URX_START;
            end
          end
          urx_pkg::URX_START:
          begin
            if (os_ff == 4'(urx_pkg::MID_SAMPLE - 1))
            begin
              os_ff <= 4'h0;
              bit_ff <= 4'h0;
              state_ff <= rx_i ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
            end
          end
          urx_pkg::URX_DATA:
          begin
            if (os_ff == 4'(urx_pkg::OVERSAMPLE - 1))
            begin
              // Nine bits when selected [RULE_14]
              rx_shift_reg_ff <= nine_bit_i ? {rx_i, rx_shift_reg_ff[8:1]} : {1'b0, rx_i, rx_shift_reg_ff[7:1]};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == (nine_bit_i ? 4'h8 : 4'h7))
              begin
                state_ff <= urx_pkg::URX_STOP;
              end
            end
          end
          urx_pkg::URX_STOP:
          begin
            if (os_ff == 4'(urx_pkg::OVERSAMPLE - 1))
            begin
              state_ff <= urx_pkg::URX_IDLE;
              done_o <= 1'b1;
              char_o <= rx_shift_reg_ff;
              framing_err_flag_o <= !rx_i; // [RULE_02]
            end
          end
        endcase
      end
    end
  end
endmodule // urx_frame_rx

// File: verif/urx_line_tx.sv
`timescale 1ns/1ps
module urx_line_tx #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk_i, // System clock
  input wire logic go_i, // Start one frame
  input wire logic [8:0] data_i, // Character to send
  input wire logic nine_i, // Nine data bits
  input wire logic bad_stop_i, // Send stop bit low
  output logic line_o, // Serial line, idle high
  output logic busy_o // Frame in progress
);
  int n;

  initial
  begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever
    begin
      do
        @(posedge clk_i);
      while (!go_i);
      busy_o <= 1'b1;
      line_o <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_i);
      n = nine_i ? 9 : 8;
      for (int i = 0; i < n; i++)
      begin
        // LSB first
        line_o <= data_i[i];
        repeat (BIT_CLKS) @(posedge clk_i);
      end
      line_o <= ~bad_stop_i;
      repeat (BIT_CLKS) @(posedge clk_i);
      // Idle gap before the next start edge
      line_o <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule // urx_line_tx

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] ON = 16'h0001 << urx_pkg::BIT_SERIAL_PORT_ON;
  localparam logic [15:0] CR = 16'h0001 << urx_pkg::BIT_CONT_RX_ON;
  localparam logic [15:0] NB = 16'h0001 << urx_pkg::BIT_NINE_BIT_SEL;
  localparam logic [15:0] FE = 16'h0001 << urx_pkg::BIT_FRAMING_ERR;
  localparam logic [15:0] OE = 16'h0001 << urx_pkg::BIT_OVERRUN_ERR;
  localparam logic [15:0] B9 = 16'h0001 << urx_pkg::BIT_NINTH_BIT;
  localparam logic [3:0] DA = urx_pkg::ADDR_RX_DATA;
  localparam logic [3:0] ST = urx_pkg::ADDR_RX_STATUS_CTRL;
  localparam logic [3:0] IS = urx_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] IM = urx_pkg::ADDR_IRQ_MASK;

  logic sys_clk, rst_i, rx_pin, wr_i, rd_i, rx_avail, irq, go, nine, bad, busy;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata;
  logic [8:0] tx_data;
  int fail_count = 0;
  int n_checks = 0;

  urx_top dut (.sys_clk_i(sys_clk), .rst_i(rst_i), .rx_pin_i(rx_pin), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .rx_avail_o(rx_avail), .irq_o(irq));

  // Divider 3: tick every 4 clocks, 16 ticks per bit
  urx_line_tx #(.BIT_CLKS(64)) line_tx (.clk_i(sys_clk), .go_i(go), .data_i(tx_data), .nine_i(nine),
    .bad_stop_i(bad), .line_o(rx_pin), .busy_o(busy));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk);
    wr_i <= 1'b0;
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge sys_clk);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk);
    rd_i <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  task automatic send(input logic [8:0] d, input logic n9, input logic stop_low);
    @(posedge sys_clk);
    go <= 1'b1;
    tx_data <= d;
    nine <= n9;
    bad <= stop_low;
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 2000 && busy; i++)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pins(input logic ea, input logic ei);
    #1;
    chk("rx_avail", {15'h0, ea}, {15'h0, rx_avail});
    chk("irq", {15'h0, ei}, {15'h0, irq});
  endtask

  initial
  begin
    #(8 * 60000);
    fail_count++;
    end_sim();
  end

  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0;
    go = 1'b0;
    tx_data = 9'h0;
    nine = 1'b0;
    bad = 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_i <= 1'b0;
    pins(1'b0, 1'b0);
    rc(ST, 16'h0, "status reset");
    rc(urx_pkg::ADDR_BAUD_DIV, urx_pkg::BAUD_DIV_RST, "baud reset");
    wr(urx_pkg::ADDR_BAUD_DIV, 16'h0003);
    wr(IM, 16'h0001);
    wr(ST, ON | CR);
    rc(DA, 16'h0, "empty data");
    rc(4'hf, 16'h0, "unmapped");
    // Good then framed-bad character
    send(9'h055, 1'b0, 1'b0);
    send(9'h03c, 1'b0, 1'b1);
    pins(1'b1, 1'b1);
    rc(ST, ON | CR, "status first");
    rc(DA, 16'h0055, "data first");
    rc(ST, ON | CR | FE, "status second");
    wr(ST, ON | FE);
    rc(ST, ON | FE, "rx off keeps frame err");
    wr(ST, 16'h0000);
    rc(ST, 16'h0, "port off");
    pins(1'b0, 1'b1);
    wr(IS, 16'h0003);
    pins(1'b0, 1'b0);
    // Frame error alone, overrun masked in
    wr(IM, 16'h0002);
    wr(ST, ON | CR);
    send(9'h00f, 1'b0, 1'b1);
    pins(1'b1, 1'b0);
    rc(IS, 16'h0001, "irq no frame source");
    rc(DA, 16'h000f, "data bad char");
    send(9'h011, 1'b0, 1'b0);
    send(9'h022, 1'b0, 1'b0);
    rc(ST, ON | CR, "two held");
    send(9'h033, 1'b0, 1'b0);
    rc(ST, ON | CR | OE, "overrun");
    pins(1'b1, 1'b1);
    rc(DA, 16'h0011, "held one");
    rc(DA, 16'h0022, "held two");
    pins(1'b0, 1'b1);
    send(9'h044, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    wr(ST, ON);
    rc(ST, ON, "overrun cleared");
    wr(IS, 16'h0002);
    pins(1'b0, 1'b0);
    // Nine-bit characters
    wr(ST, ON | CR | NB);
    send(9'h1a5, 1'b1, 1'b0);
    send(9'h05a, 1'b1, 1'b0);
    rc(ST, ON | CR | NB | B9, "ninth set");
    rc(DA, 16'h00a5, "nine low a");
    rc(ST, ON | CR | NB, "ninth clear");
    rc(DA, 16'h005a, "nine low b");
    pins(1'b0, 1'b0);
    wr(IM, 16'h0001);
    wr(ST, ON | CR);
    send(9'h0c3, 1'b0, 1'b0);
    pins(1'b1, 1'b1);
    wr(IM, 16'h0000);
    pins(1'b1, 1'b0);
    wr(IM, 16'h0001);
    wr(IS, 16'h0001);
    pins(1'b1, 1'b0);
    rc(DA, 16'h00c3, "last data");
    end_sim();
  end
endmodule // tb
